// >>> sdf_framer.sv
/*
  sdf_framer: readout end; splits card streams into per-card blocks and emits whole slices.
  assumes: cards send one block after another on the link; the downstream sink takes
  every word while out_valid is high, there is no back-pressure on the output.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - every structure is whole 32-bit words
// - slice header: size, run, frame, slice number
// - slice body holds blocks back to back
// - slice trailer: error code, then size
// - header and trailer slice sizes are equal
// - trailer error code comes from aggregation
// - aggregator header: size, run, frame, id/slice
// - aggregator trailer repeats the block size
// - aggregator body holds all card blocks
// - card header fields at fixed bit positions
// - card header keeps port, error, format and block size only
// - card words converted to card block format
// - card opens slice with header word
// - card closes slice with count trailer
// - two top bits mark header, data, trailer
// - marker bits may be stripped from data
// - card header and hit word layouts
// - card trailer holds error and hit count
module sdf_framer
  import sdf_pkg::*;
#(
  parameter int DEPTH = 1024
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  sdf_link_if.framer       link,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic [31:0]      hrdata_out,
  output logic             hresp_out,
  output logic             out_valid_out,
  output logic [31:0]      out_word_out,
  output logic             out_last_out
);
  import sdf_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    sdf_state_e  st;
    logic        ready;
    logic        out_valid;
    logic [31:0] out_word;
    logic        out_last;
    logic        in_card;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] hdr_slot;
    logic [15:0] hits;
    logic [3:0]  fmt;
    logic [3:0]  l1;
    logic [8:0]  cards;
    logic [7:0]  err;
    logic [7:0]  last_err;
    logic [15:0] pos;
    logic [15:0] body;
    logic        we;
    logic [AW-1:0] waddr;
    logic [31:0] wdata;
    logic        slice_done;
  } sdf_frm_s;
  sdf_frm_s s, next_s;
  logic [31:0] mem [DEPTH];
  logic [1:0]  ctrl;
  logic [31:0] run;
  logic [31:0] frame;
  logic [23:0] slice;
  logic [8:0]  num_cards;
  logic [3:0]  second_level_port_field;
  logic [7:0]  agg_id;

  sdf_ahb_regs u_regs (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hsize_in      (hsize_in),
    .hwdata_in     (hwdata_in),
    .hready_in     (hready_in),
    .last_err_in   (s.last_err),
    .busy_in       (s.st == ST_EMIT),
    .slice_done_in (s.slice_done),
    .hreadyout_out (hreadyout_out),
    .hrdata_out    (hrdata_out),
    .hresp_out     (hresp_out),
    .ctrl_out      (ctrl),
    .run_out       (run),
    .frame_out     (frame),
    .slice_out     (slice),
    .num_cards_out (num_cards),
    .second_level_port_field_out   (second_level_port_field),
    .agg_id_out    (agg_id)
  );

  // per-card block header; frame, run and slice live only in the slice and aggregator headers
  function automatic logic [31:0] card_hdr(input logic [3:0] l1, input logic [3:0] l2,
                                           input logic [3:0] cerr, input logic [3:0] fmt,
                                           input logic [15:0] hits);
    card_hdr = {l1, l2, cerr, fmt, hits + 16'h0001};
  endfunction

  logic [1:0]    mk;
  logic          full;
  logic          mism;
  logic [15:0]   total;
  logic [15:0]   agg_size;
  logic [AW-1:0] rd_addr;
  assign mk       = link.word[MK_HI:MK_LO];
  assign full     = s.wr_ptr == AW'(DEPTH - 1);
  assign mism     = link.word[CNT_HI:CNT_LO] != s.hits;
  assign total    = s.body + SLICE_OVH;
  assign agg_size = s.body + AGG_OVH;
  assign rd_addr  = AW'(s.pos - IX_BODY);

  always_comb begin
    next_s = s;
    next_s.we         = 1'b0;
    next_s.slice_done = 1'b0;
    next_s.out_valid  = 1'b0;
    next_s.out_last   = 1'b0;
    unique case (s.st)
      ST_COLLECT: begin
        next_s.ready = ctrl[CTRL_EN];
        if (link.valid && s.ready) begin
          unique case (mk)
            MK_HDR: begin
              if (s.in_card) begin
                // close the open block so the body stays contiguous
                next_s.we             = 1'b1;
                next_s.waddr          = s.hdr_slot;
                next_s.wdata          = card_hdr(s.l1, second_level_port_field, CARD_ERR_ORDER, s.fmt, s.hits);
                next_s.err[ERR_ORDER] = 1'b1;
                next_s.cards          = s.cards + 9'h001;
              end
              if (full) begin
                next_s.err[ERR_OVF] = 1'b1;
                next_s.in_card      = 1'b0;
              end else begin
                next_s.in_card  = 1'b1;
                next_s.hdr_slot = s.wr_ptr;
                next_s.wr_ptr   = s.wr_ptr + AW'(1);
                next_s.hits     = 16'h0000;
                next_s.fmt      = link.word[FMT_HI:FMT_LO];
                next_s.l1       = link.port;
              end
            end
            MK_DATA: begin
              if (!s.in_card) begin
                next_s.err[ERR_ORDER] = 1'b1;
              end else if (full) begin
                next_s.err[ERR_OVF] = 1'b1;
              end else begin
                next_s.we     = 1'b1;
                next_s.waddr  = s.wr_ptr;
                next_s.wdata  = ctrl[CTRL_STRIP] ? {2'h0, link.word[29:0]} : link.word;
                next_s.wr_ptr = s.wr_ptr + AW'(1);
                next_s.hits   = s.hits + 16'h0001;
              end
            end
            MK_TRL: begin
              if (s.in_card) begin
                next_s.we      = 1'b1;
                next_s.waddr   = s.hdr_slot;
                next_s.wdata   = card_hdr(s.l1, second_level_port_field,
                                          mism ? CARD_ERR_COUNT : link.word[CERR_HI:CERR_LO], s.fmt, s.hits);
                next_s.in_card = 1'b0;
                next_s.cards   = s.cards + 9'h001;
                if (mism) begin
                  next_s.err[ERR_COUNT] = 1'b1;
                end
                if (link.word[CERR_HI:CERR_LO] != 4'h0) begin
                  next_s.err[ERR_CARD] = 1'b1;
                end
              end else begin
                next_s.err[ERR_ORDER] = 1'b1;
              end
            end
            default: next_s.err[ERR_ORDER] = 1'b1;
          endcase
        end
        // every attached card has closed its block: the slice is complete
        if (ctrl[CTRL_EN] && !next_s.in_card && next_s.cards >= num_cards) begin
          next_s.st    = ST_EMIT;
          next_s.ready = 1'b0;
          next_s.body  = 16'(next_s.wr_ptr);
          next_s.pos   = 16'h0000;
        end
      end
      ST_EMIT: begin
        next_s.ready     = 1'b0;
        next_s.out_valid = 1'b1;
        next_s.pos       = s.pos + 16'h0001;
        if (s.pos == IX_SLC_SIZE) begin
          next_s.out_word = {16'h0000, total};
        end else if (s.pos == IX_SLC_RUN || s.pos == IX_AGG_RUN) begin
          next_s.out_word = run;
        end else if (s.pos == IX_SLC_FRAME || s.pos == IX_AGG_FRAME) begin
          next_s.out_word = frame;
        end else if (s.pos == IX_SLC_NUM) begin
          next_s.out_word = {8'h00, slice};
        end else if (s.pos == IX_AGG_SIZE) begin
          next_s.out_word = {16'h0000, agg_size};
        end else if (s.pos == IX_AGG_ID) begin
          next_s.out_word = {agg_id, slice};
        end else if (s.pos < IX_BODY + s.body) begin
          next_s.out_word = mem[rd_addr];
        end else if (s.pos == IX_BODY + s.body) begin
          next_s.out_word = {16'h0000, agg_size};
        end else if (s.pos == IX_BODY + s.body + AGG_TRL_WORDS) begin
          next_s.out_word = {24'h000000, s.err};
        end else begin
          next_s.out_word   = {16'h0000, total};
          next_s.out_last   = 1'b1;
          // ready rises one cycle after the last word, so no card word is taken beside it
          next_s.st         = ST_COLLECT;
          next_s.slice_done = 1'b1;
          next_s.last_err   = s.err;
          next_s.err        = 8'h00;
          next_s.cards      = 9'h000;
          next_s.wr_ptr     = '0;
          next_s.in_card    = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s    <= '0;
      s.st <= ST_COLLECT;
    end else begin
      s <= next_s;
    end
  end

  // body store; a block's header word is written into its reserved slot at close
  always_ff @(posedge sys_clk_in) begin
    if (s.we) begin
      mem[s.waddr] <= s.wdata;
    end
  end

  assign link.ready    = s.ready;
  assign out_valid_out = s.out_valid;
  assign out_word_out  = s.out_word;
  assign out_last_out  = s.out_last;
endmodule
`default_nettype wire

// >>> sdf_pkg.sv
/*
  sdf_pkg: constants, field layouts, register map and states of the slice data framer.
  assumes: shared by the card end, the framer end, its register block, the checks and the bench.
*/
package sdf_pkg;
  localparam int unsigned WORD_W = 32;
  // front-end word markers in bits 31:30
  localparam logic [1:0] MK_DATA = 2'h0;
  localparam logic [1:0] MK_RSVD = 2'h1;
  localparam logic [1:0] MK_HDR  = 2'h2;
  localparam logic [1:0] MK_TRL  = 2'h3;
  localparam int MK_HI   = 31;
  localparam int MK_LO   = 30;
  localparam int FMT_HI  = 27;
  localparam int FMT_LO  = 24;
  localparam int CERR_HI = 19;
  localparam int CERR_LO = 16;
  localparam int CNT_HI  = 15;
  localparam int CNT_LO  = 0;
  localparam int CH_W    = 12;
  localparam int TIME_W  = 16;
  localparam int FRM_W   = 8;
  localparam int CERR_W  = 12;
  // structure overheads in words
  localparam logic [15:0] SLICE_HDR_WORDS = 16'h0004;
  localparam logic [15:0] SLICE_TRL_WORDS = 16'h0002;
  localparam logic [15:0] AGG_HDR_WORDS   = 16'h0004;
  localparam logic [15:0] AGG_TRL_WORDS   = 16'h0001;
  localparam logic [15:0] AGG_OVH   = AGG_HDR_WORDS + AGG_TRL_WORDS;
  localparam logic [15:0] SLICE_OVH = SLICE_HDR_WORDS + SLICE_TRL_WORDS + AGG_OVH;
  // word index within an emitted slice
  localparam logic [15:0] IX_SLC_SIZE  = 16'h0000;
  localparam logic [15:0] IX_SLC_RUN   = 16'h0001;
  localparam logic [15:0] IX_SLC_FRAME = 16'h0002;
  localparam logic [15:0] IX_SLC_NUM   = 16'h0003;
  localparam logic [15:0] IX_AGG_SIZE  = 16'h0004;
  localparam logic [15:0] IX_AGG_RUN   = 16'h0005;
  localparam logic [15:0] IX_AGG_FRAME = 16'h0006;
  localparam logic [15:0] IX_AGG_ID    = 16'h0007;
  localparam logic [15:0] IX_BODY      = 16'h0008;
  // slice error code bits
  localparam int ERR_COUNT = 0;
  localparam int ERR_ORDER = 1;
  localparam int ERR_CARD  = 2;
  localparam int ERR_OVF   = 3;
  // per-card error code written on count mismatch or missing trailer
  localparam logic [3:0] CARD_ERR_COUNT = 4'hf;
  localparam logic [3:0] CARD_ERR_ORDER = 4'he;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_RUN    = 8'h04;
  localparam logic [7:0] REG_FRAME  = 8'h08;
  localparam logic [7:0] REG_SLICE  = 8'h0c;
  localparam logic [7:0] REG_CFG    = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_STRIP = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h1;
  localparam logic [8:0]  NUM_CARDS_RST = 9'h001;
  localparam int CFG_NC_LO  = 0;
  localparam int CFG_L2_LO  = 12;
  localparam int CFG_AID_LO = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    ST_COLLECT = 2'b01,
    ST_EMIT    = 2'b10
  } sdf_state_e;
endpackage

// >>> sdf_link_if.sv
/*
  sdf_link_if: word stream from one front-end card end to the framer end.
  assumes: both ends on sys_clk_in; a word moves when valid and ready are high at an edge.
*/
`timescale 1ns/1ps
`default_nettype none
interface sdf_link_if;
  logic        valid;
  logic        ready;
  logic [31:0] word;
  logic [3:0]  port;
  modport card   (output valid, output word, output port, input ready);
  modport framer (input valid, input word, input port, output ready);
endinterface
`default_nettype wire

// >>> sdf_ahb_regs.sv
/*
  sdf_ahb_regs: AHB-Lite slave holding the framer's control, config and status registers.
  assumes: single word transfers, one slave so hreadyout is hready; zero wait states.
*/
`timescale 1ns/1ps
`default_nettype none
module sdf_ahb_regs
  import sdf_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  input  wire logic [7:0]  last_err_in,
  input  wire logic        busy_in,
  input  wire logic        slice_done_in,
  output logic             hreadyout_out,
  output logic [31:0]      hrdata_out,
  output logic             hresp_out,
  output logic [1:0]       ctrl_out,
  output logic [31:0]      run_out,
  output logic [31:0]      frame_out,
  output logic [23:0]      slice_out,
  output logic [8:0]       num_cards_out,
  output logic [3:0]       second_level_port_field_out,
  output logic [7:0]       agg_id_out
);
  import sdf_pkg::*;
  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic [1:0]  ctrl;
    logic [31:0] run;
    logic [31:0] frame;
    logic [23:0] slice;
    logic [8:0]  num_cards;
    logic [3:0]  second_level_port_field;
    logic [7:0]  agg_id;
  } sdf_regs_s;
  sdf_regs_s s, next_s;

  always_comb begin
    next_s = s;
    // slice number advances once per emitted slice; a software write the same cycle wins
    if (slice_done_in) begin
      next_s.slice = s.slice + 24'h000001;
    end
    next_s.wr_pend = 1'b0;
    if (s.wr_pend) begin
      unique case (s.addr)
        REG_CTRL:  next_s.ctrl = hwdata_in[1:0];
        REG_RUN:   next_s.run = hwdata_in;
        REG_FRAME: next_s.frame = hwdata_in;
        REG_SLICE: next_s.slice = hwdata_in[23:0];
        REG_CFG: begin
          next_s.num_cards = hwdata_in[CFG_NC_LO +: 9];
          next_s.second_level_port_field   = hwdata_in[CFG_L2_LO +: 4];
          next_s.agg_id    = hwdata_in[CFG_AID_LO +: 8];
        end
        default: ;
      endcase
    end
    if (hsel_in && hready_in && htrans_in == HTRANS_NONSEQ) begin
      next_s.addr    = haddr_in[7:0];
      next_s.wr_pend = hwrite_in;
      // read data is captured at the address phase so the data phase has no wait state
      unique case (haddr_in[7:0])
        REG_CTRL:   next_s.rdata = {30'h0, s.ctrl};
        REG_RUN:    next_s.rdata = s.run;
        REG_FRAME:  next_s.rdata = s.frame;
        REG_SLICE:  next_s.rdata = {8'h00, s.slice};
        REG_CFG:    next_s.rdata = {8'h00, s.agg_id, s.second_level_port_field, 3'h0, s.num_cards};
        REG_STATUS: next_s.rdata = {23'h0, busy_in, last_err_in};
        default:    next_s.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s           <= '0;
      s.ctrl      <= CTRL_RST;
      s.num_cards <= NUM_CARDS_RST;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = s.rdata;
  assign ctrl_out      = s.ctrl;
  assign run_out       = s.run;
  assign frame_out     = s.frame;
  assign slice_out     = s.slice;
  assign num_cards_out = s.num_cards;
  assign second_level_port_field_out   = s.second_level_port_field;
  assign agg_id_out    = s.agg_id;
endmodule
`default_nettype wire

// >>> sdf_card.sv
/*
  sdf_card: front-end card end; wraps hits of one slice in header and trailer words.
  assumes: user pulses one of start, hit or stop only while user_ready_out is high.
*/
`timescale 1ns/1ps
`default_nettype none
module sdf_card
  import sdf_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  sdf_link_if.card               link,
  input  wire logic [3:0]        port_in,
  input  wire logic              start_in,
  input  wire logic [3:0]        fmt_in,
  input  wire logic [FRM_W-1:0]  frame_lsb_in,
  input  wire logic [15:0]       slice_lsb_in,
  input  wire logic              hit_in,
  input  wire logic [CH_W-1:0]   channel_in,
  input  wire logic [TIME_W-1:0] time_in,
  input  wire logic              stop_in,
  input  wire logic [CERR_W-1:0] err_in,
  output logic                   user_ready_out
);
  import sdf_pkg::*;
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [15:0] hits;
    logic        ready;
  } sdf_card_s;
  sdf_card_s s, next_s;

  always_comb begin
    next_s = s;
    if (link.ready && s.valid) begin
      next_s.valid = 1'b0;
    end
    // one word held at a time: simple, at half the link rate
    if (s.ready) begin
      if (start_in) begin
        next_s.word  = {MK_HDR, 2'h0, fmt_in, frame_lsb_in, slice_lsb_in};
        next_s.hits  = 16'h0000;
        next_s.valid = 1'b1;
      end else if (hit_in) begin
        // narrow channel and time fields padded to a full word
        next_s.word  = {MK_DATA, 2'h0, channel_in, time_in};
        next_s.hits  = s.hits + 16'h0001;
        next_s.valid = 1'b1;
      end else if (stop_in) begin
        next_s.word  = {MK_TRL, 2'h0, err_in, s.hits};
        next_s.valid = 1'b1;
      end
    end
    next_s.ready = !next_s.valid;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s       <= '0;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.valid     = s.valid;
  assign link.word      = s.word;
  assign link.port      = port_in;
  assign user_ready_out = s.ready;
endmodule
`default_nettype wire

// >>> sdf_link_sva.sv
/*
  sdf_link_sva: checks on the card link and on the framer's slice stream.
  assumes: placed in the bench beside the link interface; one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sdf_link_sva
  import sdf_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic        valid,
  input wire logic        ready,
  input wire logic [31:0] word,
  input wire logic        out_valid_out,
  input wire logic [31:0] out_word_out,
  input wire logic        out_last_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [15:0] idx;
  logic [31:0] first_size;
  logic [31:0] agg_size;
  // word position in the slice; a lost out_last leaves idx running and trips the length check
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      idx        <= 16'h0;
      first_size <= 32'h0;
      agg_size   <= 32'h0;
    end else if (out_valid_out) begin
      idx <= out_last_out ? 16'h0 : idx + 16'h1;
      if (idx == IX_SLC_SIZE) first_size <= out_word_out;
      if (idx == IX_AGG_SIZE) agg_size <= out_word_out;
    end
  end
  sequence s_close;
    !out_valid_out ##[0:2] ready;
  endsequence
  property p_hold;
    valid && !ready |=> valid && $stable(word);
  endproperty
  property p_mark;
    valid |-> word[MK_HI:MK_LO] != MK_RSVD;
  endproperty
  property p_busy;
    out_valid_out |-> !ready;
  endproperty
  property p_close;
    out_last_out |=> s_close;
  endproperty
  property p_size;
    out_last_out |-> out_word_out == first_size;
  endproperty
  property p_len;
    out_last_out |-> idx == first_size[15:0] - 16'h1;
  endproperty
  property p_agg;
    out_last_out |-> $past(out_word_out, 2) == agg_size && first_size == agg_size + 32'h6;
  endproperty
  property p_err;
    out_last_out |-> $past(out_word_out) < 32'h100;
  endproperty
  property p_rsvd;
    out_valid_out && idx == IX_SLC_NUM |-> out_word_out[31:24] == 8'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("card word changed before it was taken");
  a_mark: assert property (p_mark) else $error("card word with reserved marker");
  a_busy: assert property (p_busy) else $error("link ready while emitting");
  a_close: assert property (p_close) else $error("slice end not followed by idle and ready");
  a_size: assert property (p_size) else $error("trailer size differs from header size");
  a_len: assert property (p_len) else $error("slice length differs from its size word");
  a_agg: assert property (p_agg) else $error("aggregator trailer or overhead wrong");
  a_err: assert property (p_err) else $error("error word wider than 8 bits");
  a_rsvd: assert property (p_rsvd) else $error("reserved slice bits not zero");
endmodule
`default_nettype wire

// >>> tb.sv
/*
  tb: one card end feeding the framer end; slices are checked word by word.
  assumes: 100 MHz clock, one AHB-Lite master, no back-pressure on the slice output.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sdf_pkg::*;
  typedef struct {logic [3:0] ce; int nh; logic [7:0] e8;} sdf_row_s;
  localparam logic [31:0] RUN = 32'h0000_0a51;
  localparam logic [31:0] FRM = 32'h0000_0017;
  localparam logic [7:0]  AID = 8'h5c;
  localparam logic [3:0]  L2  = 4'h9;
  localparam logic [3:0]  PRT = 4'h3;
  localparam logic [3:0]  FMT = 4'h6;
  logic        sys_clk_in, rst_n_in, hsel, hwrite, hrdy, ov, ol, start, hit, stop, urdy;
  logic [31:0] haddr, hwdata, hrdata, ow, rd;
  logic [1:0]  htrans;
  logic [15:0] slsb, tm;
  logic [11:0] ch, cerr;
  logic [23:0] sn;
  logic [31:0] got[$];
  logic [31:0] pre[$];
  int          errors, comparisons;
  sdf_row_s    rows[3] = '{'{4'h0, 2, 8'h00}, '{4'h5, 0, 8'h04}, '{4'h0, 3, 8'h00}};
  sdf_link_if link();
  sdf_card i_sdf_card (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link), .port_in(PRT),
    .start_in(start), .fmt_in(FMT), .frame_lsb_in(FRM[7:0]), .slice_lsb_in(slsb), .hit_in(hit),
    .channel_in(ch), .time_in(tm), .stop_in(stop), .err_in(cerr), .user_ready_out(urdy));
  sdf_framer #(.DEPTH(64)) i_sdf_framer (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy), .hrdata_out(hrdata), .hresp_out(),
    .out_valid_out(ov), .out_word_out(ow), .out_last_out(ol));
  sdf_link_sva i_sdf_link_sva (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .valid(link.valid),
    .ready(link.ready), .word(link.word), .out_valid_out(ov), .out_word_out(ow), .out_last_out(ol));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) if (ov === 1'b1) got.push_back(ow);
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sys_clk_in); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_in); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  // pulse held until an edge that saw user ready, so a refused pulse is simply retried
  task automatic op(input logic [2:0] k);
    {start, hit, stop} <= k;
    do @(posedge sys_clk_in); while (urdy !== 1'b1);
    {start, hit, stop} <= 3'h0;
    @(posedge sys_clk_in);
  endtask
  task automatic send(input logic [3:0] ce, input int nh);
    for (int i = 0; i < nh; i++) begin
      ch <= 12'h0a0 + 12'(i);
      tm <= 16'h0100 + 16'(i);
      op(3'h2);
    end
    cerr <= {8'h0, ce};
    op(3'h1);
  endtask
  task automatic check_slice(input logic [3:0] ce, input int nh, input logic [7:0] e8);
    logic [31:0] exp[$];
    logic [15:0] b;
    logic [15:0] n;
    b = 16'(nh + 1);
    // words in pre belong to blocks closed earlier in the same slice
    n = b + 16'(pre.size());
    exp = '{32'(n + 16'd11), RUN, FRM, {8'h0, sn}, 32'(n + 16'd5), RUN, FRM, {AID, sn}};
    foreach (pre[i]) exp.push_back(pre[i]);
    pre.delete();
    exp.push_back({PRT, L2, ce, FMT, b});
    for (int i = 0; i < nh; i++) exp.push_back({4'h0, 12'h0a0 + 12'(i), 16'h0100 + 16'(i)});
    exp.push_back(32'(n + 16'd5));
    exp.push_back({24'h0, e8});
    exp.push_back(32'(n + 16'd11));
    for (int i = 0; i < 400 && got.size() < exp.size(); i++) @(negedge sys_clk_in);
    cmp32(32'(got.size()), 32'(exp.size()));
    foreach (exp[i]) if (i < got.size()) cmp32(got[i], exp[i]);
    got.delete();
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    cmp32(rd, {24'h0, e8});
    ahb(1'b0, 32'(REG_SLICE), 32'h0);
    cmp32(rd, {8'h0, sn + 24'h1});
    sn = sn + 24'h1;
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    rst_n_in <= 1'b0;
    {hsel, hwrite, start, hit, stop} <= 5'h0;
    {haddr, hwdata} <= 64'h0;
    htrans <= 2'h0;
    {slsb, tm, ch, cerr} <= 56'h0;
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    cmp32({31'h0, ov}, 32'h0);
    ahb(1'b0, 32'(REG_CTRL), 32'h0);
    cmp32(rd, 32'h1);
    ahb(1'b0, 32'h18, 32'h0);
    cmp32(rd, 32'h0);
    ahb(1'b1, 32'(REG_RUN), RUN);
    ahb(1'b1, 32'(REG_FRAME), FRM);
    ahb(1'b1, 32'(REG_SLICE), 32'h100);
    ahb(1'b1, 32'(REG_CFG), {8'h0, AID, L2, 12'h1});
    ahb(1'b0, 32'(REG_CFG), 32'h0);
    cmp32(rd, {8'h0, AID, L2, 12'h1});
    sn = 24'h100;
    foreach (rows[r]) begin
      slsb <= sn[15:0];
      op(3'h4);
      send(rows[r].ce, rows[r].nh);
      check_slice(rows[r].ce, rows[r].nh, rows[r].e8);
    end
    // disabled framer must hold the card off; nothing may be emitted meanwhile
    ahb(1'b1, 32'(REG_CTRL), 32'h0);
    slsb <= sn[15:0];
    op(3'h4);
    repeat (10) @(posedge sys_clk_in);
    cmp32({31'h0, link.valid}, 32'h1);
    cmp32(32'(got.size()), 32'h0);
    ahb(1'b1, 32'(REG_CTRL), 32'h1);
    send(4'h0, 1);
    check_slice(4'h0, 1, 8'h00);
    // a header before the trailer closes the open block with the order code
    slsb <= sn[15:0];
    op(3'h4);
    ch <= 12'h0a0;
    tm <= 16'h0100;
    op(3'h2);
    pre = '{{PRT, L2, CARD_ERR_ORDER, FMT, 16'h0002}, {4'h0, 12'h0a0, 16'h0100}};
    op(3'h4);
    send(4'h0, 0);
    check_slice(4'h0, 0, 8'h02);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
